/* File: rtl/iprio_bank_zero.sv */
// module: priority register slice zero with apb access and its arbiter
`timescale 1ns/10ps

// What this block does
// - bits 15, 11, 7 and 3 read as zero and ignore writes.
// - four 3-bit read/write priority fields sit at bits 14-12, 10-8, 6-4 and 2-0.
// - code 111 gives level 7, the highest, beating every lower code.
// - code 001 gives level 1, the lowest active level, codes between map linearly.
// - code 000 disables its source so it never raises an interrupt.
module iprio_bank_zero
    import iprio_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // arbitration result
    output logic             irq_req,
    output logic      [2:0]  irq_level,
    output logic      [1:0]  irq_source
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] ctrl_d, ctrl_q;
    logic [7:0]  req_d,  req_q;     // [3:0] flags, [7:4] enables
    logic [31:0] rdata_d, rdata_q;
    logic        ready_d, ready_q;
    logic        err_d,   err_q;
    logic        irq_q;
    logic [2:0]  lvl_q;
    logic [1:0]  src_q;
    logic        setup;
    logic        access;

    iprio_field_if fields ();

    // masks away the unimplemented bit positions
    function automatic logic [15:0] implemented(input logic [15:0] v);
        return v & IPRIO_IMPL_MASK;
    endfunction

    // merges write data into a word honouring byte strobes
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
        logic [15:0] r;
        r = old;
        if (st[0]) r[7:0]  = wd[7:0];
        if (st[1]) r[15:8] = wd[15:8];
        return r;
    endfunction

    // a setup cycle: answered with pready one cycle later in the access phase
    assign setup = psel && !penable;
    // the access edge that samples pready high; writes land here and nowhere else
    assign access = psel && penable && ready_q;

    // ------------------------------------------------------------
    // register write and read decode
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d  = ctrl_q;
        req_d   = req_q;
        rdata_d = rdata_q;
        ready_d = 1'b0;
        err_d   = 1'b0;
        if (setup) begin
            ready_d = 1'b1;
            rdata_d = 32'h0000_0000;
            if (paddr == IPRIO_CTRL_ZERO_OFFSET) begin
                if (!pwrite)
                    rdata_d = {16'h0000, implemented(ctrl_q)};
            end else if (paddr == IPRIO_REQUEST_OFFSET) begin
                if (!pwrite)
                    rdata_d = {24'h00_0000, req_q};
            end else if (paddr == IPRIO_STATUS_OFFSET) begin
                if (pwrite)
                    err_d = 1'b1;
                else
                    rdata_d = {26'h000_0000, irq_q, src_q, lvl_q};
            end else begin
                err_d = 1'b1;                                            // unmapped address
            end
        end
        // write effect only at the edge that closes the access phase
        if (access && pwrite) begin
            if (paddr == IPRIO_CTRL_ZERO_OFFSET)
                ctrl_d = implemented(merge(ctrl_q, pwdata, pstrb));
            else if (paddr == IPRIO_REQUEST_OFFSET)
                req_d = pstrb[0] ? pwdata[7:0] : req_q;
        end
    end

    // registers; write effect lands at the edge that closes the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= IPRIO_CTRL_RESET;
            req_q   <= 8'h00;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            req_q   <= req_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q   <= err_d;
        end
    end

    // ------------------------------------------------------------
    // fields to the arbiter
    // ------------------------------------------------------------
    assign fields.timer_one_priority    = ctrl_q[IPRIO_TIMER_LSB   +: 3];
    assign fields.compare_one_priority  = ctrl_q[IPRIO_COMPARE_LSB +: 3];
    assign fields.capture_one_priority  = ctrl_q[IPRIO_CAPTURE_LSB +: 3];
    assign fields.ext_irq_zero_priority = ctrl_q[IPRIO_EXT_LSB     +: 3];
    assign fields.pending               = req_q[3:0] & req_q[7:4];

    iprio_arbiter u_arb (
        .pclk    (pclk),
        .presetn (presetn),
        .fields  (fields)
    );

    assign irq_q = fields.irq_valid;
    assign lvl_q = fields.irq_level;
    assign src_q = fields.irq_source;

    // outputs straight from flip-flops
    assign prdata     = rdata_q;
    assign pready     = ready_q;
    assign pslverr    = err_q;
    assign irq_req    = irq_q;
    assign irq_level  = lvl_q;
    assign irq_source = src_q;

endmodule // iprio_bank_zero

/* File: rtl/iprio_pkg.sv */
// package: register map, field layout and reset values of the priority register slice
package iprio_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] IPRIO_CTRL_ZERO_OFFSET = 12'h000;   // interrupt_priority_control_zero
    localparam logic [11:0] IPRIO_STATUS_OFFSET    = 12'h004;   // arbitration result, read only
    localparam logic [11:0] IPRIO_REQUEST_OFFSET   = 12'h008;   // request flags and enables
    localparam int          IPRIO_REG_WIDTH        = 16;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int          IPRIO_TIMER_LSB    = 12;
    localparam int          IPRIO_COMPARE_LSB  = 8;
    localparam int          IPRIO_CAPTURE_LSB  = 4;
    localparam int          IPRIO_EXT_LSB      = 0;
    localparam int          IPRIO_NUM_SRC      = 4;
    localparam logic [15:0] IPRIO_IMPL_MASK    = 16'h7777;   // bits 15, 11, 7 and 3 absent

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0]  IPRIO_FIELD_RESET  = 3'h4;
    localparam logic [15:0] IPRIO_CTRL_RESET   = 16'h4444;
    localparam logic [2:0]  IPRIO_LEVEL_OFF    = 3'h0;

    // source index
    typedef enum logic [1:0] {
        IPRIO_SRC_EXT     = 2'b00,
        IPRIO_SRC_CAPTURE = 2'b01,
        IPRIO_SRC_COMPARE = 2'b10,
        IPRIO_SRC_TIMER   = 2'b11
    } iprio_src_type;

endpackage

/* File: rtl/iprio_field_if.sv */
// interface: priority fields handed from the register slice to the arbiter
`timescale 1ns/10ps
interface iprio_field_if;
    logic [2:0]  timer_one_priority;
    logic [2:0]  compare_one_priority;
    logic [2:0]  capture_one_priority;
    logic [2:0]  ext_irq_zero_priority;
    logic [3:0]  pending;              // request flag and enable per source
    logic        irq_valid;
    logic [2:0]  irq_level;
    logic [1:0]  irq_source;

    modport regs (output timer_one_priority, compare_one_priority, capture_one_priority,
                  output ext_irq_zero_priority, pending, input irq_valid, irq_level, irq_source);
    modport arb  (input timer_one_priority, compare_one_priority, capture_one_priority,
                  input ext_irq_zero_priority, pending, output irq_valid, irq_level, irq_source);
endinterface // iprio_field_if

/* File: rtl/iprio_arbiter.sv */
// module: picks the pending source with the highest non-zero priority level
`timescale 1ns/10ps
module iprio_arbiter
    import iprio_pkg::*;
(
    // clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // priority fields and result
    iprio_field_if.arb fields
);

    logic       valid_d, valid_q;
    logic [2:0] level_d, level_q;
    logic [1:0] src_d,   src_q;
    logic [2:0] lvl [IPRIO_NUM_SRC];

    // level 1..7 is the code itself, higher code wins; code 000 never competes
    always_comb begin
        lvl[0]  = fields.ext_irq_zero_priority;
        lvl[1]  = fields.capture_one_priority;
        lvl[2]  = fields.compare_one_priority;
        lvl[3]  = fields.timer_one_priority;
        valid_d = 1'b0;
        level_d = IPRIO_LEVEL_OFF;
        src_d   = IPRIO_SRC_EXT;
        for (int i = 0; i < IPRIO_NUM_SRC; i++) begin
            if (fields.pending[i] && (lvl[i] != IPRIO_LEVEL_OFF) && (lvl[i] > level_d)) begin
                valid_d = 1'b1;
                level_d = lvl[i];
                src_d   = 2'(i);
            end
        end
    end

    // result registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_q <= 1'b0;
            level_q <= IPRIO_LEVEL_OFF;
            src_q   <= IPRIO_SRC_EXT;
        end else begin
            valid_q <= valid_d;
            level_q <= level_d;
            src_q   <= src_d;
        end
    end

    assign fields.irq_valid  = valid_q;
    assign fields.irq_level  = level_q;
    assign fields.irq_source = src_q;

endmodule // iprio_arbiter

/* File: verif/iprio_bank_zero_props.sv */
// checker: apb timing, reserved bits and priority result of the register slice
`timescale 1ns/10ps
module iprio_bank_zero_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // arbitration result
    input wire logic        irq_req,
    input wire logic [2:0]  irq_level
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // setup cycle and a good read of the control word
    sequence setup_s; psel && !penable; endsequence
    sequence ctrl_read_s; pready && !pwrite && !pslverr && paddr == 12'h000; endsequence
    // apb answer comes one cycle after setup and lasts one cycle
    AST_SETUP_READY: assert property (setup_s |=> pready && penable)
        else $error("no ready one cycle after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_UNMAPPED_ERR: assert property (setup_s ##0 paddr == 12'h00C |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    // absent bits always read zero
    AST_RSVD_READ: assert property (ctrl_read_s |-> (prdata & 32'hFFFF8888) == 32'h0)
        else $error("absent bit read as one");
    // a raised request always carries an active level, an idle one level zero
    AST_REQ_LEVEL: assert property (irq_req |-> irq_level != 3'h0)
        else $error("request raised with level zero");
    AST_IDLE_LEVEL: assert property (!irq_req |-> irq_level == 3'h0)
        else $error("level shown without request");
endmodule // iprio_bank_zero_chk

bind iprio_bank_zero iprio_bank_zero_chk chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_req(irq_req), .irq_level(irq_level));

/* File: verif/tb_iprio_bank_zero.sv */
// testbench: apb register access and arbitration of the priority register slice
`timescale 1ns/10ps
module tb_iprio_bank_zero;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'h0;
    logic [3:0]  strb    = 4'h3;
    logic [31:0] prdata, rd, wd;
    logic        pready, pslverr, irq_req, err;
    logic [2:0]  irq_level;
    logic [1:0]  irq_source;
    logic [6:0]  exp_irq;
    int          errors = 0, n_compared = 0, ctrl, pend;

    // 250 MHz clock
    always #2 pclk = ~pclk;

    iprio_bank_zero dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_req(irq_req), .irq_level(irq_level), .irq_source(irq_source));

    // verdict and end of run
    task end_sim();
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one comparison
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer, held until ready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd  = prdata;
        err = pslverr;
        if (i == 16) begin
            errors++;
            end_sim();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // model: highest active level among pending sources, lowest index on a tie
    function automatic logic [6:0] win(input int c, input int p);
        int i, b, s;
        b = 0;
        s = 0;
        for (i = 0; i < 4; i++) begin
            if (p[i] && ((c >> (4 * i)) & 7) > b) begin
                b = (c >> (4 * i)) & 7;
                s = i;
            end
        end
        return {b != 0, s[1:0], 1'b0, b[2:0]};
    endfunction

    // main sequence
    initial begin
        void'($urandom(10));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk("reset ctrl", 32'h4444, rd);
        for (int k = 0; k < 40; k++) begin
            wd = (k < 8) ? 32'h1111 * k : $urandom;
            ctrl = wd & 32'h7777;
            pend = $urandom & 32'hFF;
            apb(1'b1, 12'h000, wd);
            apb(1'b1, 12'h008, pend);
            apb(1'b0, 12'h000, 32'h0);
            chk("ctrl", ctrl, rd);
            chk("ctrl err", 32'h0, err);
            repeat (2) @(posedge pclk);
            exp_irq = win(ctrl, pend & (pend >> 4) & 15);
            chk("irq", exp_irq, {irq_req, irq_source, 1'b0, irq_level});
            apb(1'b0, 12'h004, 32'h0);
            chk("status", {exp_irq[6:4], exp_irq[2:0]}, rd);
        end
        // byte strobes: only the strobed lane of the control word changes
        strb = 4'h2;
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk("high strobe", ctrl & 32'hFF, rd);
        strb = 4'h1;
        apb(1'b1, 12'h000, 32'hFFFF);
        apb(1'b0, 12'h000, 32'h0);
        chk("low strobe", 32'h77, rd);
        strb = 4'h3;
        // the status word refuses writes and an unmapped address is refused
        apb(1'b1, 12'h004, 32'h0);
        chk("status write err", 32'h1, err);
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped err", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
        end_sim();
    end
endmodule // tb_iprio_bank_zero
